// >>> design/lpcsc_pkg.sv
package lpcsc_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] PWR_CTRL_ADDR = 5'h00; // power_control_reg
  localparam logic [4:0] PWR_MGMT_ADDR = 5'h04; // power_mgmt_reg
  localparam logic [4:0] EXT_FLAG_ADDR = 5'h08; // ext_int_flag_reg
  localparam logic [4:0] EXT_EN_ADDR   = 5'h0C; // external wake enables

  // power_control_reg fields
  localparam int IDLE_BIT = 0; // idle request, cleared by hardware
  localparam int STOP_BIT = 1; // stop request, cleared by hardware
  localparam int OSC_FAIL_DETECT_ENABLE_BIT = 4; // osc_fail_detect_enable
  localparam int OFDF_BIT = 5; // osc fail flag, write 0 to clear

  // power_mgmt_reg fields
  localparam int DIV_HI_BIT = 7; // clock_divide_hi
  localparam int DIV_LO_BIT = 6; // clock_divide_lo

  // ext_int_flag_reg fields
  localparam int RSEL_BIT = 1; // ring_clock_select
  localparam int RACT_BIT = 2; // ring_clock_active, read only
  localparam int BGS_BIT  = 3; // bandgap_stop_select

  // clock divide encodings
  localparam logic [1:0] DIV_BY1    = 2'h2; // one osc cycle per machine cycle
  localparam logic [1:0] DIV_BY1024 = 2'h3; // 1024 osc cycles per machine cycle

  // wake sources and warmup counts
  localparam int          N_EXT_INT         = 6;
  localparam int          CNT_W             = 17;
  localparam int unsigned XTAL_WARM_PERIODS = 65536; // crystal periods
  localparam int unsigned FLASH_WARM_CYCLES = 65536; // clock cycles
  localparam logic [23:0] RD_PAD            = 24'h000000;

  // power state, one-hot
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_IDLE = 4'h2,
    ST_STOP = 4'h4,
    ST_WARM = 4'h8
  } lpcsc_state_t;

  // complete state of the controller
  typedef struct packed {
    lpcsc_state_t         state;
    logic                 idle;
    logic                 stop;
    logic                 osc_fail_detect_enable;
    logic                 ofdf;
    logic [1:0]           div;
    logic                 ring_sel;
    logic                 bandgap_stop_select;
    logic                 ring_active;
    logic                 ring_path;
    logic [N_EXT_INT-1:0] ext_en;
    logic                 ack;
    logic [7:0]           rdata;
    logic                 rst_pulse;
  } lpcsc_regs_t;

  // warmup counter state
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             done;
  } lpcsc_cnt_t;

endpackage : lpcsc_pkg

// >>> design/lpcsc_warm_counter.sv
`timescale 1ns/1ns
`default_nettype none

module lpcsc_warm_counter #(
  parameter int unsigned LIMIT = lpcsc_pkg::FLASH_WARM_CYCLES
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // control
  input  wire logic clear_in,
  // status
  output logic      done_out
);

  // limit at counter width
  localparam logic [lpcsc_pkg::CNT_W-1:0] LIMIT_V = LIMIT[lpcsc_pkg::CNT_W-1:0];
  localparam logic [lpcsc_pkg::CNT_W-1:0] ONE_V   = 17'h00001;

  lpcsc_pkg::lpcsc_cnt_t cnt_q; // current count
  lpcsc_pkg::lpcsc_cnt_t cnt_d; // next count

  // saturating count, held at zero while cleared
  always_comb begin
    cnt_d = cnt_q;
    if (clear_in) begin
      cnt_d.count = '0;
    end else if (cnt_q.count != LIMIT_V) begin
      cnt_d.count = cnt_q.count + ONE_V;
    end
    cnt_d.done = !clear_in && (cnt_d.count == LIMIT_V);
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = cnt_q.done;

endmodule : lpcsc_warm_counter

`default_nettype wire

// >>> design/lpcsc_ctrl.sv
// Behaviour
// [RULE1] crystal off for the whole of stop
// [RULE2] ring clocks system until crystal ready
// [RULE3] no ring: hold execution during crystal warmup
// [RULE4] readable status bit shows ring clock source
// [RULE5] divider forced divide-by-1 while on ring
// [RULE6] watchdog only ever clocked from crystal
// [RULE7] idle bit freezes fetch and execution
// [RULE8] idle keeps state and peripheral clocks
// [RULE9] enabled interrupt ends idle, clears bit
// [RULE10] resume right after idle-entering instruction
// [RULE11] any reset ends idle mode
// [RULE12] stop bit halts every on-chip clock
// [RULE13] enabled external interrupt ends stop
// [RULE14] reset pin always ends stop mode
// [RULE15] bandgap reset in stop only if selected
// [RULE16] flash warmup wait after stop exit
// [RULE17] no oscillator-fail reset caused by stop
// [RULE18] divide field 11b slow, reset to 10b
// [RULE19] stop bit cleared when stop ends
`timescale 1ns/1ns
`default_nettype none

module lpcsc_ctrl #(
  parameter int unsigned XTAL_WARM_PERIODS = lpcsc_pkg::XTAL_WARM_PERIODS,
  parameter int unsigned FLASH_WARM_CYCLES = lpcsc_pkg::FLASH_WARM_CYCLES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // wake and reset sources
  input  wire logic [5:0]  ext_int_in,
  input  wire logic        irq_pending_in,
  input  wire logic        ext_reset_in,
  input  wire logic        supply_low_in,
  input  wire logic        crystal_fail_in,
  // clock and core control
  output logic             crystal_enable_out,
  output logic             ring_osc_enable_out,
  output logic             ring_clock_active_out,
  output logic             watchdog_clk_enable_out,
  output logic             periph_clk_enable_out,
  output logic             cpu_hold_out,
  output logic [1:0]       clock_divide_out,
  output logic             osc_fail_detect_enable_out,
  output logic             internal_reset_out,
  output logic             idle_mode_out,
  output logic             stop_mode_out
);

  lpcsc_pkg::lpcsc_regs_t q; // registered state
  lpcsc_pkg::lpcsc_regs_t d; // next state

  logic       flash_done; // flash warmup elapsed
  logic       xtal_done;  // crystal warmup elapsed
  logic       warm_clr;   // counters idle outside warmup
  logic       wr_fire;    // write accepted this edge
  logic       rd_load;    // read data captured this edge
  logic       ext_rst;    // reset pin
  logic       bg_rst;     // bandgap reset in stop
  logic       ofd_rst;    // oscillator fail reset
  logic       any_rst;    // any internal reset source
  logic       stop_wake;  // enabled external wake in stop
  logic [7:0] rd_mux;     // selected register image
  logic       in_stop;    // state decodes
  logic       in_warm;
  logic       in_idle;
  logic       in_run;

  assign in_stop  = (q.state == lpcsc_pkg::ST_STOP);
  assign in_warm  = (q.state == lpcsc_pkg::ST_WARM);
  assign in_idle  = (q.state == lpcsc_pkg::ST_IDLE);
  assign in_run   = (q.state == lpcsc_pkg::ST_RUN);
  assign warm_clr = !in_warm;

  // flash warmup timer, counted on the system clock
  lpcsc_warm_counter #(
    .LIMIT (FLASH_WARM_CYCLES)
  ) u_flash_cnt (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (warm_clr),
    .done_out   (flash_done)
  );

  // crystal startup timer, also counted on the system clock
  lpcsc_warm_counter #(
    .LIMIT (XTAL_WARM_PERIODS)
  ) u_xtal_cnt (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (warm_clr),
    .done_out   (xtal_done)
  );

  // one wait state: waitrequest drops on the second cycle of an access
  assign wr_fire = avs_write_in && q.ack;
  assign rd_load = avs_read_in && !q.ack;

  // reset sources
  assign ext_rst   = ext_reset_in;
  assign bg_rst    = in_stop && q.bandgap_stop_select && supply_low_in; // RULE15
  // crystal is deliberately off in stop and still starting in warmup
  assign ofd_rst   = crystal_fail_in && q.osc_fail_detect_enable && !in_stop && !in_warm; // RULE17
  assign any_rst   = ext_rst || bg_rst || ofd_rst;
  assign stop_wake = in_stop && (|(ext_int_in & q.ext_en)); // RULE13

  // register read image
  always_comb begin
    rd_mux = 8'h00;
    unique case (avs_address_in)
      lpcsc_pkg::PWR_CTRL_ADDR: begin
        rd_mux[lpcsc_pkg::IDLE_BIT] = q.idle;
        rd_mux[lpcsc_pkg::STOP_BIT] = q.stop;
        rd_mux[lpcsc_pkg::OSC_FAIL_DETECT_ENABLE_BIT] = q.osc_fail_detect_enable;
        rd_mux[lpcsc_pkg::OFDF_BIT] = q.ofdf;
      end
      lpcsc_pkg::PWR_MGMT_ADDR: begin
        rd_mux[lpcsc_pkg::DIV_HI_BIT] = q.div[1];
        rd_mux[lpcsc_pkg::DIV_LO_BIT] = q.div[0];
      end
      lpcsc_pkg::EXT_FLAG_ADDR: begin
        rd_mux[lpcsc_pkg::RSEL_BIT] = q.ring_sel;
        rd_mux[lpcsc_pkg::RACT_BIT] = q.ring_active; // RULE4
        rd_mux[lpcsc_pkg::BGS_BIT]  = q.bandgap_stop_select;
      end
      lpcsc_pkg::EXT_EN_ADDR: begin
        rd_mux[lpcsc_pkg::N_EXT_INT-1:0] = q.ext_en;
      end
      // unmapped offsets read as zero
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // next-state logic: bus writes first, hardware events override
  always_comb begin
    d           = q;
    d.ack       = (avs_read_in || avs_write_in) && !q.ack;
    d.rst_pulse = any_rst;
    if (rd_load) begin
      d.rdata = rd_mux;
    end
    // software writes, low byte lane only
    if (wr_fire && avs_byteenable_in[0]) begin
      unique case (avs_address_in)
        lpcsc_pkg::PWR_CTRL_ADDR: begin
          if (avs_writedata_in[lpcsc_pkg::IDLE_BIT]) begin
            d.idle = 1'b1;
          end
          if (avs_writedata_in[lpcsc_pkg::STOP_BIT]) begin
            d.stop = 1'b1;
          end
          d.osc_fail_detect_enable = avs_writedata_in[lpcsc_pkg::OSC_FAIL_DETECT_ENABLE_BIT];
          if (!avs_writedata_in[lpcsc_pkg::OFDF_BIT]) begin
            d.ofdf = 1'b0;
          end
        end
        lpcsc_pkg::PWR_MGMT_ADDR: begin
          // divider locked while the ring supplies the clock
          if (!q.ring_active) begin // RULE5
            d.div = {avs_writedata_in[lpcsc_pkg::DIV_HI_BIT],
                     avs_writedata_in[lpcsc_pkg::DIV_LO_BIT]}; // RULE18
          end
        end
        lpcsc_pkg::EXT_FLAG_ADDR: begin
          d.ring_sel = avs_writedata_in[lpcsc_pkg::RSEL_BIT];
          d.bandgap_stop_select      = avs_writedata_in[lpcsc_pkg::BGS_BIT];
        end
        lpcsc_pkg::EXT_EN_ADDR: begin
          d.ext_en = avs_writedata_in[lpcsc_pkg::N_EXT_INT-1:0];
        end
        // unmapped writes are dropped
        default: begin
          d.ext_en = q.ext_en;
        end
      endcase
    end
    // power state sequencing
    unique case (q.state)
      lpcsc_pkg::ST_RUN: begin
        // stop wins if both bits are set together
        if (d.stop) begin
          d.state = lpcsc_pkg::ST_STOP; // RULE12
          d.idle  = 1'b0;
        end else if (d.idle) begin
          d.state = lpcsc_pkg::ST_IDLE; // RULE7
        end
      end
      lpcsc_pkg::ST_IDLE: begin
        // core is frozen; a stop bit written over the bus during idle is discarded here
        d.stop = 1'b0;
        if (irq_pending_in) begin
          d.state = lpcsc_pkg::ST_RUN; // RULE9
          d.idle  = 1'b0;              // RULE9
        end
      end
      lpcsc_pkg::ST_STOP: begin
        if (stop_wake) begin
          d.state       = lpcsc_pkg::ST_WARM;
          d.stop        = 1'b0;       // RULE19
          d.ring_path   = q.ring_sel; // RULE2
          d.ring_active = q.ring_sel; // RULE2
          if (q.ring_sel) begin
            d.div = lpcsc_pkg::DIV_BY1; // RULE5
          end
        end
      end
      lpcsc_pkg::ST_WARM: begin
        // ring handed back to the crystal once it is stable
        if (xtal_done) begin
          d.ring_active = 1'b0; // RULE2
        end
        if (xtal_done && flash_done) begin // RULE3
          d.state     = lpcsc_pkg::ST_RUN; // RULE16
          d.ring_path = 1'b0;
        end
      end
      // illegal one-hot code recovers to run
      default: begin
        d.state = lpcsc_pkg::ST_RUN;
      end
    endcase
    // any reset source ends idle and stop; flag set beats clear
    if (any_rst) begin
      d.idle        = 1'b0;               // RULE11
      d.stop        = 1'b0;               // RULE19
      d.div         = lpcsc_pkg::DIV_BY1; // RULE18
      d.ring_active = 1'b0;
      d.ring_path   = 1'b0;
      // crystal may still be cold, so warm it up on the crystal path
      if (in_stop || in_warm) begin
        d.state = lpcsc_pkg::ST_WARM; // RULE14
      end else begin
        d.state = lpcsc_pkg::ST_RUN;  // RULE11
      end
      if (bg_rst) begin
        d.osc_fail_detect_enable = 1'b0;
      end
      if (ofd_rst) begin
        d.ofdf = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q          <= '0;
      q.state    <= lpcsc_pkg::ST_RUN;
      q.div      <= lpcsc_pkg::DIV_BY1; // RULE18
    end else begin
      q <= d;
    end
  end

  // bus outputs
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.ack;
  assign avs_readdata_out    = {lpcsc_pkg::RD_PAD, q.rdata};

  // clock control outputs
  assign crystal_enable_out      = !in_stop; // RULE1
  assign ring_osc_enable_out     = q.ring_active; // RULE2
  assign ring_clock_active_out   = q.ring_active; // RULE4
  // watchdog sees only a stable crystal, never the ring
  // ring handback lands one edge after crystal warmup, so wait for it
  assign watchdog_clk_enable_out = in_run || in_idle
                                   || (in_warm && xtal_done && !q.ring_active); // RULE6
  assign periph_clk_enable_out   = in_run || in_idle
                                   || (in_warm && q.ring_path && flash_done); // RULE8
  // pc simply stays put, so execution resumes after the entering instruction
  assign cpu_hold_out = in_idle || in_stop || (in_warm && !(q.ring_path && flash_done)); // RULE10
  assign clock_divide_out           = q.div;
  assign osc_fail_detect_enable_out = q.osc_fail_detect_enable;
  assign internal_reset_out         = q.rst_pulse;
  assign idle_mode_out              = in_idle;
  assign stop_mode_out              = in_stop;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_stop_exit;
    in_stop && stop_wake && !any_rst;
  endsequence

  sequence s_ring_ready;
    in_warm && q.ring_path && xtal_done && !any_rst;
  endsequence

  a_stop_xtal_off: assert property (in_stop |-> !crystal_enable_out && !periph_clk_enable_out) // RULE1
    else $error("crystal running in stop");
  a_ring_handback: assert property (s_ring_ready |=> !ring_clock_active_out && !ring_osc_enable_out) // RULE2
    else $error("ring not released after crystal warmup");
  a_xtal_hold: assert property (in_warm && !q.ring_path && !xtal_done |-> cpu_hold_out) // RULE3
    else $error("execution before crystal warmup");
  a_ring_status: assert property (rd_load && avs_address_in == lpcsc_pkg::EXT_FLAG_ADDR
      |=> avs_readdata_out[lpcsc_pkg::RACT_BIT] == $past(ring_clock_active_out)) // RULE4
    else $error("ring status bit wrong");
  a_div_locked: assert property (ring_clock_active_out |-> clock_divide_out == lpcsc_pkg::DIV_BY1) // RULE5
    else $error("divider not divide-by-1 on ring");
  a_wdt_crystal: assert property (watchdog_clk_enable_out |-> crystal_enable_out && !ring_clock_active_out) // RULE6
    else $error("watchdog clocked without crystal");
  a_idle_enter: assert property (in_run && wr_fire && avs_address_in == lpcsc_pkg::PWR_CTRL_ADDR
      && avs_byteenable_in[0] && avs_writedata_in[1:0] == 2'h1 && !any_rst
      |=> cpu_hold_out && idle_mode_out && periph_clk_enable_out) // RULE7
    else $error("idle not entered");
  a_idle_wake: assert property (in_idle && irq_pending_in && !any_rst |=> !q.idle && !cpu_hold_out) // RULE9
    else $error("idle not left on interrupt");
  a_idle_reset: assert property (in_idle && any_rst |=> !idle_mode_out && !q.idle) // RULE11
    else $error("reset did not end idle");
  a_stop_exit: assert property (s_stop_exit |=> !stop_mode_out && !q.stop ##0 cpu_hold_out[*8]) // RULE13
    else $error("stop exit or flash hold wrong");
  a_pin_reset: assert property (in_stop && ext_reset_in |=> !stop_mode_out && internal_reset_out) // RULE14
    else $error("reset pin did not end stop");
  a_bandgap_rst: assert property (in_stop && supply_low_in && !ext_reset_in
      |=> internal_reset_out == $past(q.bandgap_stop_select)) // RULE15
    else $error("bandgap reset mismatch");
  a_osc_fail_stop: assert property (in_stop && !ext_reset_in && !supply_low_in |=> !internal_reset_out) // RULE17
    else $error("spurious reset in stop");
  a_div_on_reset: assert property (any_rst |=> clock_divide_out == lpcsc_pkg::DIV_BY1) // RULE18
    else $error("divider not restored on reset");
  a_idle_clocks: assert property (in_idle |-> periph_clk_enable_out && watchdog_clk_enable_out) // RULE8
    else $error("peripheral clocks stopped in idle");
  a_stop_halt: assert property (in_stop |-> cpu_hold_out && !watchdog_clk_enable_out) // RULE12
    else $error("clocks or core running in stop");
  a_warm_flash: assert property (in_warm && !flash_done |-> cpu_hold_out) // RULE16
    else $error("execution before flash warmup");
  a_stop_clear: assert property (in_stop && any_rst |=> !stop_mode_out && !q.stop) // RULE19
    else $error("stop bit kept after reset");

endmodule : lpcsc_ctrl

`default_nettype wire

// >>> tb/lpcsc_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none

module lpcsc_ctrl_tb;
  // shortened warmups keep the run brief; crystal longer than flash on purpose
  localparam int unsigned XW = 40; // crystal warmup cycles
  localparam int unsigned FW = 16; // flash warmup cycles

  logic        clk_in = 1'b0;       // 10 MHz system clock
  logic        reset_n_in;          // async reset, active low
  logic [4:0]  avs_address_in;      // bus byte address
  logic        avs_read_in;         // bus read
  logic        avs_write_in;        // bus write
  logic [31:0] avs_writedata_in;    // bus write data
  logic [3:0]  avs_byteenable_in;   // bus byte enables
  logic [31:0] avs_readdata_out;    // bus read data
  logic        avs_waitrequest_out; // bus stall
  logic [5:0]  ext_int_in;          // external wake levels
  logic        irq_pending_in;      // idle wake
  logic        ext_reset_in;        // reset pin
  logic        supply_low_in;       // supply under threshold
  logic        crystal_fail_in;     // crystal too slow
  logic        crystal_enable_out, ring_osc_enable_out, ring_clock_active_out;
  logic        watchdog_clk_enable_out, periph_clk_enable_out, cpu_hold_out;
  logic [1:0]  clock_divide_out;
  logic        osc_fail_detect_enable_out, internal_reset_out;
  logic        idle_mode_out, stop_mode_out;
  int          fails;               // mismatches
  int          check_count;         // comparisons
  int          cycles;              // clock cycles since start
  int          t0;                  // start of a timed wait
  logic [31:0] rd;                  // last read data

  lpcsc_ctrl #(.XTAL_WARM_PERIODS(XW), .FLASH_WARM_CYCLES(FW)) i_lpcsc_ctrl (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ext_int_in(ext_int_in),
    .irq_pending_in(irq_pending_in), .ext_reset_in(ext_reset_in),
    .supply_low_in(supply_low_in), .crystal_fail_in(crystal_fail_in),
    .crystal_enable_out(crystal_enable_out), .ring_osc_enable_out(ring_osc_enable_out),
    .ring_clock_active_out(ring_clock_active_out),
    .watchdog_clk_enable_out(watchdog_clk_enable_out),
    .periph_clk_enable_out(periph_clk_enable_out), .cpu_hold_out(cpu_hold_out),
    .clock_divide_out(clock_divide_out),
    .osc_fail_detect_enable_out(osc_fail_detect_enable_out),
    .internal_reset_out(internal_reset_out), .idle_mode_out(idle_mode_out),
    .stop_mode_out(stop_mode_out));

  // clock generator, 100 ns period
  always #50 clk_in = ~clk_in;

  // hang guard: far above the few hundred cycles the tests need
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end

  // compare and count; unknowns never match
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one avalon access; request held until waitrequest is sampled low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] wd,
           input logic [3:0] be, output logic [31:0] d);
    @(posedge clk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= {24'h000000, wd};
    avs_byteenable_in <= be;
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    // answer and read data both taken at the accepting edge; hang guard ends a stall
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  // shorthands for full-byte writes and reads
  task wr(input logic [4:0] a, input logic [7:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, 4'hF, dummy);
  endtask : wr

  task rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF, rd);
    check(rd, exp);
  endtask : rd_chk

  // let n edges pass, then sample where outputs are settled
  task settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // drive a wake or reset source level just after an edge
  task wake(input logic [5:0] ei, input logic irq, input logic rst, input logic sl);
    @(posedge clk_in);
    ext_int_in     <= ei;
    irq_pending_in <= irq;
    ext_reset_in   <= rst;
    supply_low_in  <= sl;
  endtask : wake

  // bounded wait for execution to resume
  task wait_run();
    for (int n = 0; n < 200 && cpu_hold_out !== 1'b0; n++) @(negedge clk_in);
  endtask : wait_run

  // verdict, the single exit of the run
  task test_done();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  initial begin
    {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hF;
    {ext_int_in, irq_pending_in, ext_reset_in, supply_low_in, crystal_fail_in} = '0;
    {fails, check_count, cycles} = '0;
    reset_n_in = 1'b0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // reset values, unmapped place, ignored byte lane
    rd_chk(lpcsc_pkg::PWR_MGMT_ADDR, 32'h00000080);
    rd_chk(lpcsc_pkg::PWR_CTRL_ADDR, 32'h00000000);
    rd_chk(5'h10, 32'h00000000);
    wr(lpcsc_pkg::PWR_MGMT_ADDR, 8'hC0);
    settle(0);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1024);
    bus(1'b1, lpcsc_pkg::PWR_MGMT_ADDR, 8'h80, 4'hE, rd);
    rd_chk(lpcsc_pkg::PWR_MGMT_ADDR, 32'h000000C0);
    $display("test registers done");
    // idle entered, peripherals kept, interrupt wakes and clears the bit
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h01);
    settle(1);
    check({idle_mode_out, cpu_hold_out}, 2'h3);
    check({periph_clk_enable_out, watchdog_clk_enable_out, crystal_enable_out}, 3'h7);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1024);
    wake(6'h00, 1'b1, 1'b0, 1'b0);
    settle(2);
    check({idle_mode_out, cpu_hold_out}, 2'h0);
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    rd_chk(lpcsc_pkg::PWR_CTRL_ADDR, 32'h00000000);
    check(cpu_hold_out, 1'b0);
    // idle left by the reset pin, divider back to divide-by-1
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h01);
    wake(6'h00, 1'b0, 1'b1, 1'b0);
    settle(1);
    check({idle_mode_out, internal_reset_out}, 2'h1);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1);
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    settle(2);
    $display("test idle done");
    // stop on crystal path; disabled wake ignored, no osc-fail reset
    wr(lpcsc_pkg::EXT_EN_ADDR, 8'h04);
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h12);
    settle(1);
    check({stop_mode_out, crystal_enable_out, cpu_hold_out}, 3'h5);
    check({periph_clk_enable_out, watchdog_clk_enable_out}, 2'h0);
    @(posedge clk_in);
    crystal_fail_in <= 1'b1;
    wake(6'h3B, 1'b0, 1'b0, 1'b0);
    settle(5);
    check({stop_mode_out, internal_reset_out}, 2'h2);
    wake(6'h04, 1'b0, 1'b0, 1'b0);
    settle(0);
    t0 = cycles;
    settle(2);
    check({stop_mode_out, ring_clock_active_out, crystal_enable_out}, 3'h1);
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    crystal_fail_in <= 1'b0;
    wait_run();
    check(cycles - t0 >= XW && cycles - t0 <= XW + 4, 1'b1);
    check(internal_reset_out, 1'b0);
    rd_chk(lpcsc_pkg::PWR_CTRL_ADDR, 32'h00000010);
    // detector still fires outside stop, and sets its flag
    @(posedge clk_in);
    crystal_fail_in <= 1'b1;
    settle(1);
    check({internal_reset_out, osc_fail_detect_enable_out}, 2'h3);
    @(posedge clk_in);
    crystal_fail_in <= 1'b0;
    rd_chk(lpcsc_pkg::PWR_CTRL_ADDR, 32'h00000030);
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h00);
    $display("test stop crystal done");
    // stop on ring path: divider locked, watchdog waits for crystal
    wr(lpcsc_pkg::EXT_FLAG_ADDR, 8'h02);
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h02);
    wake(6'h04, 1'b0, 1'b0, 1'b0);
    settle(0);
    t0 = cycles;
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    settle(1);
    check({ring_clock_active_out, ring_osc_enable_out, cpu_hold_out}, 3'h7);
    check(watchdog_clk_enable_out, 1'b0);
    rd_chk(lpcsc_pkg::EXT_FLAG_ADDR, 32'h00000006);
    wr(lpcsc_pkg::PWR_MGMT_ADDR, 8'hC0);
    settle(0);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1);
    wait_run();
    check(cycles - t0 >= FW && cycles - t0 <= FW + 4, 1'b1);
    check({ring_clock_active_out, periph_clk_enable_out}, 2'h3);
    for (int n = 0; n < 200 && ring_clock_active_out !== 1'b0; n++) @(negedge clk_in);
    check(cycles - t0 >= XW && cycles - t0 <= XW + 4, 1'b1);
    check({ring_osc_enable_out, watchdog_clk_enable_out}, 2'h1);
    rd_chk(lpcsc_pkg::EXT_FLAG_ADDR, 32'h00000002);
    wr(lpcsc_pkg::PWR_MGMT_ADDR, 8'hC0);
    settle(0);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1024);
    wr(lpcsc_pkg::EXT_FLAG_ADDR, 8'h00);
    $display("test stop ring done");
    // stop left by the reset pin; bandgap reset only when selected
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h02);
    wake(6'h00, 1'b0, 1'b0, 1'b1);
    settle(3);
    check({stop_mode_out, internal_reset_out}, 2'h2);
    wake(6'h00, 1'b0, 1'b1, 1'b0);
    settle(1);
    check({stop_mode_out, internal_reset_out}, 2'h1);
    check(clock_divide_out, lpcsc_pkg::DIV_BY1);
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    wait_run();
    rd_chk(lpcsc_pkg::PWR_CTRL_ADDR, 32'h00000000);
    wr(lpcsc_pkg::EXT_FLAG_ADDR, 8'h08);
    wr(lpcsc_pkg::PWR_CTRL_ADDR, 8'h02);
    wake(6'h00, 1'b0, 1'b0, 1'b1);
    settle(1);
    check({stop_mode_out, internal_reset_out}, 2'h1);
    wake(6'h00, 1'b0, 1'b0, 1'b0);
    wait_run();
    $display("test stop reset done");
    test_done();
  end
endmodule : lpcsc_ctrl_tb

`default_nettype wire
